// File: hw/scf_pkg.sv
// Purpose: Shared constants for the smart card interface control registers.
// Assumes: AXI4-Lite with 32-bit data, 12-bit byte addresses.
// Notes:   Register indices are kept as printed; byte address is four times the index.
package scf_pkg;

	// ----------------------------------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [9:0]  IDX_CONTACTS   = 10'h0FE;
	localparam logic [9:0]  IDX_IFACE      = 10'h0FF;
	localparam logic [11:0] ADDR_CONTACTS  = {IDX_CONTACTS, 2'b00};
	localparam logic [11:0] ADDR_IFACE     = {IDX_IFACE, 2'b00};
	localparam logic [11:0] ADDR_WAIT0     = 12'h000;
	localparam logic [11:0] ADDR_WAIT1     = 12'h004;
	localparam logic [11:0] ADDR_WAIT2     = 12'h008;
	localparam logic [11:0] ADDR_WAIT3     = 12'h00C;
	localparam logic [11:0] ADDR_STATUS    = 12'h010;
	localparam logic [11:0] ADDR_CONFIG    = 12'h014;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTL_SOFT_RESET   = 7;
	localparam int CTL_PRES_POL     = 6;
	localparam int CTL_VSEL_HI      = 5;
	localparam int CTL_VSEL_LO      = 4;
	localparam int CTL_UART_SEL     = 3;
	localparam int CTL_WAIT_EN      = 2;
	localparam int CTL_REPEAT_EN    = 1;
	localparam int CTL_CONVENTION   = 0;
	localparam int CON_CLK_SEL      = 7;
	localparam int CON_C8_LEVEL     = 5;
	localparam int CON_IO_LEVEL     = 3;
	localparam int CON_CLK_LEVEL    = 2;
	localparam int CON_POWER_ON     = 0;
	localparam int STA_VOLT_GOOD    = 3;
	localparam int STA_PRESENT      = 2;
	localparam int STA_WAIT_TIMEOUT = 1;
	localparam int STA_PARITY_ERR   = 0;
	localparam int CFG_REPEAT_SEL   = 0;

	// ----------------------------------------------------------------
	// Reset values, masks and counts
	// ----------------------------------------------------------------
	localparam logic [7:0] IFACE_RESET    = 8'h00;
	localparam logic [7:0] CONTACTS_RESET = 8'h00;
	localparam logic [7:0] CONTACTS_MASK  = 8'hBF;
	localparam logic [3:0] ACT_TICKS      = 4'h4;
	localparam logic [2:0] RX_SIGNALS_LO  = 3'h4;
	localparam logic [2:0] RX_SIGNALS_HI  = 3'h5;
	localparam logic [2:0] TX_RESENDS_LO  = 3'h3;
	localparam logic [2:0] TX_RESENDS_HI  = 3'h4;

	// ----------------------------------------------------------------
	// Card supply encodings and bus answers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SCF_V1P0_A = 2'b00,
		SCF_V1P0_B = 2'b01,
		SCF_V3P0   = 2'b10,
		SCF_V5P0   = 2'b11
	} scf_volt_e;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: hw/scf_sync2.sv
// Purpose: Two-stage synchroniser for a group of pin levels.
// Assumes: Inputs are asynchronous to clk.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps
module scf_sync2 #(
	parameter int WIDTH = 5
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (reset) begin
					meta_q[i]   <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					meta_q[i]   <= async_in[i];
					sync_out[i] <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule

// File: hw/scf_clk_switch.sv
// Purpose: Glitch-free selection of the card clock pin source.
// Assumes: link_level is the synchronised link clock level.
// Notes:   The source changes only when both candidates show the same level.
`timescale 1ns/1ps
module scf_clk_switch (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic enable,
	input  wire logic use_link,
	input  wire logic link_level,
	input  wire logic static_level,
	output logic      pin_out
);

	logic using_link_q;
	wire  logic agree = (link_level == static_level);
	wire  logic src   = using_link_q ? link_level : static_level;

	always_ff @(posedge clk) begin
		if (reset) begin
			using_link_q <= 1'b0;
			pin_out      <= 1'b0;
		end else begin
			if (agree) begin
				using_link_q <= use_link;
			end
			pin_out <= enable ? src : 1'b0;
		end
	end

endmodule

// File: hw/scf_ctrl.sv
// Purpose: Interface and contacts control registers of the smart card block.
// Assumes: AXI4-Lite slave on clk; link clock and pads are sampled, not clocked on.
// Notes:   CPU writes reach the interface copy on the next link clock edge.
`timescale 1ns/1ps
module scf_ctrl (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        card_interface_clock,
	input  wire logic        card_present_input,
	input  wire logic        supply_in_range,
	input  wire logic        converter_on,
	input  wire logic        card_io_in,
	output logic             card_io_out,
	output logic             card_io_oe_n,
	input  wire logic        card_c8_in,
	output logic             card_c8_out,
	output logic             card_c8_oe_n,
	output logic             card_clk_pin,
	output logic             card_power_en,
	output logic [1:0]       card_voltage_code,
	input  wire logic        uart_tx_level,
	output logic             uart_rx_level,
	input  wire logic        start_bit_seen,
	input  wire logic        rx_parity_error,
	input  wire logic        tx_repeat_request,
	output logic             rx_signal_error,
	output logic             tx_resend,
	output logic             msb_first,
	output logic             presence_event,
	output logic             card_present,
	output logic             wait_timeout
);

	// ----------------------------------------------------------------
	// Pin synchronisation and link clock edges
	// ----------------------------------------------------------------
	logic [4:0] pins_s;
	logic       link_prev_q;

	scf_sync2 #(.WIDTH(5)) u_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in ({card_interface_clock, card_present_input, supply_in_range,
		            card_io_in, card_c8_in}),
		.sync_out (pins_s)
	);

	wire logic link_lvl  = pins_s[4];
	wire logic pres_lvl  = pins_s[3];
	wire logic range_lvl = pins_s[2];
	wire logic io_lvl    = pins_s[1];
	wire logic c8_lvl    = pins_s[0];
	wire logic link_tick = link_lvl & ~link_prev_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			link_prev_q <= 1'b0;
		end else begin
			link_prev_q <= link_lvl;
		end
	end

	// ----------------------------------------------------------------
	// Bus side registers
	// ----------------------------------------------------------------
	logic [7:0]  cpu_iface_q;
	logic [7:0]  cpu_contacts_q;
	logic [7:0]  wait_byte_q [4];
	logic        repeat_sel_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	wire logic        wr_fire  = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
	wire logic        wr_lane  = wr_fire & s_axi_wstrb[0];
	wire logic [7:0]  wr_byte  = s_axi_wdata[7:0];
	wire logic        wr_iface = wr_lane & (s_axi_awaddr == scf_pkg::ADDR_IFACE);
	wire logic        wr_cont  = wr_lane & (s_axi_awaddr == scf_pkg::ADDR_CONTACTS);
	wire logic        wr_stat  = wr_lane & (s_axi_awaddr == scf_pkg::ADDR_STATUS);
	wire logic        wr_cfg   = wr_lane & (s_axi_awaddr == scf_pkg::ADDR_CONFIG);
	wire logic        wr_wait2 = wr_lane & (s_axi_awaddr == scf_pkg::ADDR_WAIT2);
	wire logic        wr_hit   = (s_axi_awaddr == scf_pkg::ADDR_IFACE)
	                           | (s_axi_awaddr == scf_pkg::ADDR_CONTACTS)
	                           | (s_axi_awaddr == scf_pkg::ADDR_STATUS)
	                           | (s_axi_awaddr == scf_pkg::ADDR_CONFIG)
	                           | (s_axi_awaddr[11:4] == 8'h00 && s_axi_awaddr[1:0] == 2'b00);

	assign s_axi_awready = wr_fire;
	assign s_axi_wready  = wr_fire;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			bvalid_q <= 1'b0;
			bresp_q  <= scf_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? scf_pkg::RESP_OKAY : scf_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Soft reset lives in the CPU copy so it can be cleared while the rest is held.
	always_ff @(posedge clk) begin
		if (reset) begin
			cpu_iface_q    <= scf_pkg::IFACE_RESET;
			cpu_contacts_q <= scf_pkg::CONTACTS_RESET;
			repeat_sel_q   <= 1'b0;
		end else begin
			if (wr_iface) begin
				cpu_iface_q <= wr_byte;
			end
			if (wr_cont) begin
				cpu_contacts_q <= wr_byte & scf_pkg::CONTACTS_MASK;
			end
			if (wr_cfg) begin
				repeat_sel_q <= wr_byte[scf_pkg::CFG_REPEAT_SEL];
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_wait_byte
			always_ff @(posedge clk) begin
				if (reset) begin
					wait_byte_q[gi] <= 8'h00;
				end else if (wr_lane && s_axi_awaddr == {8'h00, 2'(gi), 2'b00}) begin
					wait_byte_q[gi] <= wr_byte;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Interface side copies, updated on link clock edges
	// ----------------------------------------------------------------
	logic [7:0] iface_q;
	logic [7:0] contacts_q;
	logic [3:0] act_cnt_q;
	logic       soft_q;
	logic       busy_q;

	wire logic if_rst = reset | soft_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			soft_q <= 1'b0;
		end else if (link_tick) begin
			soft_q <= cpu_iface_q[scf_pkg::CTL_SOFT_RESET];
		end
	end

	always_ff @(posedge clk) begin
		if (if_rst) begin
			iface_q    <= scf_pkg::IFACE_RESET;
			contacts_q <= scf_pkg::CONTACTS_RESET;
		end else if (link_tick) begin
			iface_q    <= cpu_iface_q;
			contacts_q <= cpu_contacts_q;
		end
	end

	// Activation countdown after soft reset is released.
	always_ff @(posedge clk) begin
		if (if_rst) begin
			act_cnt_q <= scf_pkg::ACT_TICKS;
			busy_q    <= 1'b1;
		end else if (link_tick && busy_q) begin
			act_cnt_q <= act_cnt_q - 4'h1;
			busy_q    <= (act_cnt_q != 4'h1);
		end
	end

	wire logic       pol     = iface_q[scf_pkg::CTL_PRES_POL];
	wire logic       uart_on = iface_q[scf_pkg::CTL_UART_SEL];
	wire logic       wait_en = iface_q[scf_pkg::CTL_WAIT_EN];
	wire logic       rep_en  = iface_q[scf_pkg::CTL_REPEAT_EN];
	wire logic       bit_order_convention    = iface_q[scf_pkg::CTL_CONVENTION];
	wire logic       power   = contacts_q[scf_pkg::CON_POWER_ON];
	wire scf_pkg::scf_volt_e vsel = scf_pkg::scf_volt_e'(iface_q[5:4]);

	// ----------------------------------------------------------------
	// Card presence and supply
	// ----------------------------------------------------------------
	logic present_q;
	logic vgood_q;

	wire logic present_d = pol ? pres_lvl : ~pres_lvl;

	always_ff @(posedge clk) begin
		if (if_rst) begin
			present_q      <= 1'b0;
			presence_event <= 1'b0;
			vgood_q        <= 1'b0;
		end else begin
			present_q      <= present_d;
			presence_event <= (present_d ^ present_q) & ~busy_q;
			vgood_q        <= power & converter_on & range_lvl;
		end
	end

	assign card_present      = present_q;
	assign card_power_en     = power & converter_on;
	assign card_voltage_code = vsel;

	// ----------------------------------------------------------------
	// Contact pins
	// ----------------------------------------------------------------
	logic io_src_q;
	logic c8_hold_q;
	logic clk_level_q;

	wire logic tx_line = bit_order_convention ? ~uart_tx_level : uart_tx_level;
	wire logic io_sel  = uart_on ? tx_line : contacts_q[scf_pkg::CON_IO_LEVEL];

	// Pad levels follow the register only while the card voltage is good.
	always_ff @(posedge clk) begin
		if (if_rst || !power) begin
			io_src_q    <= 1'b0;
			c8_hold_q   <= 1'b0;
			clk_level_q <= 1'b0;
		end else if (vgood_q) begin
			io_src_q    <= io_sel;
			c8_hold_q   <= contacts_q[scf_pkg::CON_C8_LEVEL];
			clk_level_q <= contacts_q[scf_pkg::CON_CLK_LEVEL];
		end
	end

	assign card_io_out   = 1'b0;
	assign card_io_oe_n  = io_src_q;
	assign card_c8_out   = 1'b0;
	assign card_c8_oe_n  = c8_hold_q;
	assign uart_rx_level = bit_order_convention ? ~io_lvl : io_lvl;
	assign msb_first     = bit_order_convention;

	scf_clk_switch u_clk_switch (
		.clk          (clk),
		.reset        (if_rst),
		.enable       (power),
		.use_link     (contacts_q[scf_pkg::CON_CLK_SEL]),
		.link_level   (link_lvl),
		.static_level (clk_level_q),
		.pin_out      (card_clk_pin)
	);

	// ----------------------------------------------------------------
	// Waiting time counter
	// ----------------------------------------------------------------
	logic [31:0] hold_q;
	logic [31:0] wcount_q;
	logic        wait_en_q;
	logic        timeout_q;

	wire logic wait_start  = wait_en & ~wait_en_q;
	wire logic wait_reload = wait_start | (wait_en & uart_on & start_bit_seen);

	always_ff @(posedge clk) begin
		if (if_rst) begin
			hold_q <= 32'h0000_0000;
		end else if (wr_wait2 && !wait_en) begin
			hold_q <= {wait_byte_q[3], wr_byte, wait_byte_q[1], wait_byte_q[0]};
		end
	end

	always_ff @(posedge clk) begin
		if (if_rst) begin
			wcount_q  <= 32'h0000_0000;
			wait_en_q <= 1'b0;
			timeout_q <= 1'b0;
		end else begin
			wait_en_q <= wait_en;
			if (wait_reload) begin
				wcount_q  <= hold_q;
				timeout_q <= 1'b0;
			end else if (wait_en && link_tick && !timeout_q) begin
				if (wcount_q == 32'h0000_0000) begin
					timeout_q <= 1'b1;
				end else begin
					wcount_q <= wcount_q - 32'h0000_0001;
				end
			end
		end
	end

	assign wait_timeout = timeout_q;

	// ----------------------------------------------------------------
	// Character repetition
	// ----------------------------------------------------------------
	logic [2:0] err_cnt_q;
	logic       parity_q;

	wire logic [2:0] rx_limit = repeat_sel_q ? scf_pkg::RX_SIGNALS_HI : scf_pkg::RX_SIGNALS_LO;
	wire logic [2:0] tx_limit = repeat_sel_q ? scf_pkg::TX_RESENDS_HI : scf_pkg::TX_RESENDS_LO;
	wire logic       rx_ev    = rep_en & rx_parity_error;
	wire logic       tx_ev    = rep_en & tx_repeat_request;
	wire logic [2:0] cnt_inc  = err_cnt_q + 3'h1;
	wire logic       rx_last  = rx_ev & (cnt_inc >= rx_limit);
	wire logic       tx_last  = tx_ev & (err_cnt_q >= tx_limit);
	wire logic       pe_set   = rx_last | tx_last | (rx_parity_error & ~rep_en);
	wire logic       pe_clr   = wr_stat & ~wr_byte[scf_pkg::STA_PARITY_ERR];

	always_ff @(posedge clk) begin
		if (if_rst) begin
			err_cnt_q       <= 3'h0;
			rx_signal_error <= 1'b0;
			tx_resend       <= 1'b0;
		end else begin
			rx_signal_error <= rx_ev;
			tx_resend       <= tx_ev & ~tx_last;
			if (rx_last || tx_last || start_bit_seen && !(rx_ev || tx_ev)) begin
				err_cnt_q <= 3'h0;
			end else if (rx_ev || tx_ev) begin
				err_cnt_q <= cnt_inc;
			end
		end
	end

	// Hardware set wins over a software clear in the same cycle.
	always_ff @(posedge clk) begin
		if (if_rst) begin
			parity_q <= 1'b0;
		end else if (pe_set) begin
			parity_q <= 1'b1;
		end else if (pe_clr) begin
			parity_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	wire logic [7:0] rd_iface = {cpu_iface_q[7] | busy_q, iface_q[6:0]};
	wire logic [7:0] rd_cont  = {contacts_q[7], 1'b0, c8_lvl, contacts_q[4],
	                             contacts_q[3:0]};
	wire logic [7:0] rd_stat  = {4'h0, vgood_q, present_q, timeout_q, parity_q};
	wire logic [7:0] rd_byte  =
		(s_axi_araddr == scf_pkg::ADDR_IFACE)    ? rd_iface :
		(s_axi_araddr == scf_pkg::ADDR_CONTACTS) ? rd_cont :
		(s_axi_araddr == scf_pkg::ADDR_STATUS)   ? rd_stat :
		(s_axi_araddr == scf_pkg::ADDR_CONFIG)   ? {7'h00, repeat_sel_q} :
		(s_axi_araddr[11:4] == 8'h00)            ? wait_byte_q[s_axi_araddr[3:2]] : 8'h00;
	wire logic       rd_hit   = (s_axi_araddr == scf_pkg::ADDR_IFACE)
	                          | (s_axi_araddr == scf_pkg::ADDR_CONTACTS)
	                          | (s_axi_araddr == scf_pkg::ADDR_STATUS)
	                          | (s_axi_araddr == scf_pkg::ADDR_CONFIG)
	                          | (s_axi_araddr[11:4] == 8'h00 && s_axi_araddr[1:0] == 2'b00);

	always_ff @(posedge clk) begin
		if (reset) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= scf_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q  <= {24'h00_0000, rd_byte};
			rresp_q  <= rd_hit ? scf_pkg::RESP_OKAY : scf_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule

// File: sim/scf_ctrl_assertions.sv
// Purpose: Port assertions for the control register block.
// Assumes: One clock domain with synchronous active-high reset.
// Notes:   Attached to every scf_ctrl instance by the bind below.
`timescale 1ns/1ps
module scf_ctrl_assertions (
	input wire logic clk,
	input wire logic reset,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic converter_on,
	input wire logic card_power_en,
	input wire logic rx_parity_error,
	input wire logic rx_signal_error,
	input wire logic tx_repeat_request,
	input wire logic tx_resend,
	input wire logic card_clk_pin,
	input wire logic card_c8_oe_n,
	input wire logic card_io_oe_n
);
	logic [5:0] off_q;
	default clocking dc @(posedge clk); endclocking
	// Counts cycles with the converter running and card power held off.
	always_ff @(posedge clk) begin
		if (reset || card_power_en || !converter_on) begin
			off_q <= 6'h00;
		end else if (off_q != 6'h3F) begin
			off_q <= off_q + 6'h01;
		end
	end
	a_power_gate: assert property (!converter_on |-> !card_power_en)
		else $error("card power on with converter off");
	a_pins_unpowered: assert property (off_q == 6'h3F |->
		!card_clk_pin && !card_c8_oe_n && !card_io_oe_n) else $error("contacts live unpowered");
	a_reset_pins: assert property (reset |=> !card_clk_pin && !card_c8_oe_n && !s_axi_bvalid)
		else $error("pins not low after reset");
	a_rx_signal: assert property (disable iff (reset) rx_signal_error |-> $past(rx_parity_error))
		else $error("error signal without cause");
	a_tx_resend: assert property (disable iff (reset) tx_resend |-> $past(tx_repeat_request))
		else $error("resend without request");
	a_wr_answer: assert property (disable iff (reset) s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write not answered");
	a_rd_answer: assert property (disable iff (reset) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_bresp_hold: assert property (disable iff (reset) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_rresp_hold: assert property (disable iff (reset) s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read answer dropped");
endmodule
bind scf_ctrl scf_ctrl_assertions u_sva (.clk(clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .converter_on(converter_on), .card_power_en(card_power_en),
	.rx_parity_error(rx_parity_error), .rx_signal_error(rx_signal_error),
	.tx_repeat_request(tx_repeat_request), .tx_resend(tx_resend), .card_clk_pin(card_clk_pin),
	.card_c8_oe_n(card_c8_oe_n), .card_io_oe_n(card_io_oe_n));

// File: sim/scf_card_model.sv
// Purpose: Card side: contact pads, presence switch and supply sense.
// Assumes: I/O and C8 lines have pull-ups and the card leaves them released.
// Notes:   The supply reads in range 15 cycles after power is enabled.
`timescale 1ns/1ps
module scf_card_model #(
	parameter bit CLOSED = 1'b0
) (
	input  wire logic clk,
	input  wire logic inserted,
	input  wire logic card_io_oe_n,
	input  wire logic card_c8_oe_n,
	input  wire logic card_power_en,
	output logic      card_io_in,
	output logic      card_c8_in,
	output logic      card_present_input,
	output logic      supply_in_range
);
	logic [3:0] ramp_q;
	assign card_io_in         = card_io_oe_n;
	assign card_c8_in         = card_c8_oe_n;
	assign card_present_input = inserted ~^ CLOSED;
	assign supply_in_range    = ramp_q == 4'hF;
	always_ff @(posedge clk) begin
		if (!card_power_en) begin
			ramp_q <= 4'h0;
		end else if (ramp_q != 4'hF) begin
			ramp_q <= ramp_q + 4'h1;
		end
	end
endmodule

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the smart card control registers.
// Assumes: Bus answers are compared against notes queued by the driver.
// Notes:   The link clock runs at 160 ns with an unrelated phase.
`timescale 1ns/1ps
module tb_top;
	logic        clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, pv;
	logic        s_axi_rready, card_interface_clock, converter_on, uart_tx_level, inserted;
	logic        start_bit_seen, rx_parity_error, tx_repeat_request, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, card_io_in, card_io_out, card_io_oe_n;
	logic        card_c8_in, card_c8_out, card_c8_oe_n, card_clk_pin, card_power_en, uart_rx_level;
	logic        rx_signal_error, tx_resend, msb_first, presence_event, card_present, wait_timeout;
	logic        card_present_input, supply_in_range, prev;
	logic [1:0]  s_axi_bresp, s_axi_rresp, card_voltage_code, expb_q[$];
	logic [3:0]  s_axi_wstrb;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [7:0]  rv, wb;
	logic [33:0] exp_q[$], msk_q[$];
	int          fails, n_checks, n, n_ev;
	scf_ctrl DUT (.*);
	scf_card_model u_card (.*);
	task automatic cmp(input string w, input logic [33:0] e, input logic [33:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic chk(input string w, input logic e, input logic g);
		cmp(w, {33'h0, e}, {33'h0, g});
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
		expb_q.push_back(r);
		@(posedge clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do @(posedge clk); while (!s_axi_awready);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid  <= 1'b0;
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready  <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF,
		input logic [1:0] r = 2'h0);
		exp_q.push_back({r, 24'h0, e & m});
		msk_q.push_back({26'h3FFFFFF, m});
		@(posedge clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_rvalid);
		s_axi_rready  <= 1'b0;
		rv = s_axi_rdata[7:0];
	endtask
	task automatic rep(input logic tx);
		@(posedge clk);
		rx_parity_error   <= !tx;
		tx_repeat_request <= tx;
		@(posedge clk);
		rx_parity_error   <= 1'b0;
		tx_repeat_request <= 1'b0;
		@(posedge clk);
		pv = tx ? tx_resend : rx_signal_error;
	endtask
	task automatic settle();
		repeat (80) @(posedge clk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		if (presence_event) n_ev++;
		if (s_axi_bvalid && s_axi_bready) begin
			cmp("bresp", {32'h0, expb_q.pop_front()}, {32'h0, s_axi_bresp});
		end
		if (s_axi_rvalid && s_axi_rready) begin
			cmp("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata} & msk_q.pop_front());
		end
	end
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		card_interface_clock = 1'b0;
		#3.3;
		forever #80 card_interface_clock = ~card_interface_clock;
	end
	initial begin
		#400000;
		fails++;
		report_and_stop();
	end
	initial begin
		reset = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{uart_tx_level, start_bit_seen, rx_parity_error, tx_repeat_request, inserted} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb  = 4'hF;
		converter_on = 1'b1;
		void'($urandom(32'hB1C5DEAD));
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		rd(scf_pkg::ADDR_CONTACTS, scf_pkg::CONTACTS_RESET);
		rd(scf_pkg::ADDR_IFACE, scf_pkg::IFACE_RESET, 8'h7F);
		rd(12'h100, 8'h00, 8'hFF, scf_pkg::RESP_SLVERR);
		wr(12'h100, 8'hFF, scf_pkg::RESP_SLVERR);
		for (int v = 0; v < 4; v++) begin
			wr(scf_pkg::ADDR_IFACE, {2'h0, 2'(v), 4'h1});
			settle();
			chk("vcode", 1'b1, card_voltage_code === 2'(v));
			chk("msb_first", 1'b1, msb_first);
			rd(scf_pkg::ADDR_IFACE, {2'h0, 2'(v), 4'h1});
		end
		$display("codes done");
		wr(scf_pkg::ADDR_IFACE, 8'h20);
		wr(scf_pkg::ADDR_CONTACTS, 8'h21);
		settle();
		chk("msb_first", 1'b0, msb_first);
		chk("power", 1'b1, card_power_en);
		chk("c8_oe_n", 1'b1, card_c8_oe_n);
		rd(scf_pkg::ADDR_STATUS, 8'h08, 8'h08);
		converter_on <= 1'b0;
		settle();
		chk("power", 1'b0, card_power_en);
		rd(scf_pkg::ADDR_STATUS, 8'h00, 8'h08);
		converter_on <= 1'b1;
		wr(scf_pkg::ADDR_CONTACTS, 8'hA1);
		settle();
		n = 0;
		repeat (200) begin
			@(posedge clk);
			if (card_clk_pin && !prev) n++;
			prev = card_clk_pin;
		end
		chk("clk_edges", 1'b1, n >= 9 && n <= 11);
		wr(scf_pkg::ADDR_CONTACTS, 8'h25);
		settle();
		chk("clk_level", 1'b1, card_clk_pin);
		wr(scf_pkg::ADDR_CONTACTS, 8'h24);
		settle();
		chk("unpowered", 1'b1, !card_clk_pin && !card_c8_oe_n);
		$display("power done");
		wr(scf_pkg::ADDR_IFACE, 8'h80);
		settle();
		wr(scf_pkg::ADDR_IFACE, 8'h00);
		rd(scf_pkg::ADDR_IFACE, 8'h80, 8'h80);
		n = 0;
		do begin
			rd(scf_pkg::ADDR_IFACE, 8'h00, 8'h00);
			n++;
		end while (rv[7] !== 1'b0 && n < 100);
		chk("activated", 1'b1, n > 2 && n < 100);
		for (int i = 0; i < 4; i++) begin
			wb = 8'($urandom());
			wr(12'(4 * i), wb);
			rd(12'(4 * i), wb);
		end
		for (int i = 0; i < 4; i++) begin
			wr(12'(4 * (i ^ (i >> 1))), (i == 0) ? 8'h03 : 8'h00);
		end
		wr(scf_pkg::ADDR_IFACE, 8'h04);
		n = 0;
		while (wait_timeout !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk("wait_span", 1'b1, n >= 40 && n <= 120);
		rd(scf_pkg::ADDR_STATUS, 8'h02, 8'h02);
		wr(scf_pkg::ADDR_IFACE, 8'h0C);
		settle();
		start_bit_seen <= 1'b1;
		@(posedge clk);
		start_bit_seen <= 1'b0;
		@(posedge clk);
		chk("reload", 1'b0, wait_timeout);
		$display("reset and wait done");
		wr(scf_pkg::ADDR_IFACE, 8'h02);
		settle();
		for (int k = 0; k < 8; k++) begin
			rep(k >= 4);
			if (k % 4 < 3) begin
				chk("repeat_pulse", 1'b1, pv);
				rd(scf_pkg::ADDR_STATUS, 8'h00, 8'h01);
			end else begin
				rd(scf_pkg::ADDR_STATUS, 8'h01, 8'h01);
				wr(scf_pkg::ADDR_STATUS, 8'h00);
			end
		end
		wr(scf_pkg::ADDR_CONFIG, 8'h01);
		repeat (4) rep(1'b0);
		rd(scf_pkg::ADDR_STATUS, 8'h00, 8'h01);
		rep(1'b0);
		rd(scf_pkg::ADDR_STATUS, 8'h01, 8'h01);
		wr(scf_pkg::ADDR_IFACE, 8'h00);
		settle();
		rep(1'b0);
		chk("repeat_off", 1'b0, pv);
		inserted <= 1'b1;
		settle();
		chk("present", 1'b1, card_present);
		wr(scf_pkg::ADDR_IFACE, 8'h40);
		settle();
		chk("present", 1'b0, card_present);
		chk("events", 1'b1, n_ev == 2);
		wr(scf_pkg::ADDR_CONTACTS, 8'h09);
		wr(scf_pkg::ADDR_IFACE, 8'h08);
		settle();
		chk("io_uart", 1'b0, card_io_oe_n);
		chk("rx_level", 1'b0, uart_rx_level);
		$display("repeat and presence done");
		report_and_stop();
	end
endmodule
